// file: hw/pvic_pkg.sv
package pvic_pkg;

	// ------------------------------------------------------------
	// register byte addresses (low twelve address bits)
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_PEND0 = 12'hfc0;
	localparam logic [11:0] ADDR_PEND2 = 12'hfc4;
	localparam logic [11:0] ADDR_PEND3 = 12'hfc8;
	localparam logic [11:0] ADDR_CTRL = 12'hfcc;
	localparam logic [11:0] ADDR_LVLH0 = 12'hfd0;
	localparam logic [11:0] ADDR_LVLL0 = 12'hfd4;
	localparam logic [11:0] ADDR_LVLH2 = 12'hfd8;
	localparam logic [11:0] ADDR_LVLL2 = 12'hfdc;
	localparam logic [11:0] ADDR_LVLH3 = 12'hfe0;
	localparam logic [11:0] ADDR_LVLL3 = 12'hfe4;
	localparam logic [11:0] ADDR_EDGEA = 12'hfe8;
	localparam logic [11:0] ADDR_EDGEX = 12'hfec;
	localparam logic [11:0] ADDR_STAT = 12'hff0;

	// ------------------------------------------------------------
	// fields, masks and reset values
	// ------------------------------------------------------------
	localparam int CTRL_GIE_BIT = 7;
	localparam int STAT_REQ_BIT = 8;
	localparam logic [7:0] MASK_G0 = 8'hf9;
	localparam logic [7:0] MASK_G2 = 8'hff;
	localparam logic [7:0] MASK_G3 = 8'hcf;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_EDGE = 8'hff;

	// ------------------------------------------------------------
	// vector addresses
	// ------------------------------------------------------------
	localparam logic [7:0] VEC_WDOG = 8'h04;
	localparam logic [7:0] VEC_OSCF = 8'h48;
	localparam logic [7:0] VEC_G0 = 8'h08;
	localparam logic [7:0] VEC_G2 = 8'h28;
	localparam logic [7:0] VEC_G3 = 8'h38;
	localparam logic [4:0] IDX_WDOG = 5'h00;
	localparam logic [4:0] IDX_OSCF = 5'h01;
	localparam logic [4:0] IDX_GRP = 5'h02;
	localparam logic [1:0] LVL_TOP = 2'h3;

	// on-chip sources, each a one-cycle pulse
	typedef struct packed {
		logic timer2;
		logic timer1;
		logic timer0;
		logic serial_rx;
		logic serial_tx;
		logic twowire;
		logic lvd;
		logic timer_a;
		logic mct;
		logic wdog;
		logic osc_fail;
	} pvic_src_t;

	// cpu events, each a one-cycle pulse
	typedef struct packed {
		logic ack;
		logic enable_int_instr;
		logic disable_int_instr;
		logic int_return_instr;
		logic trap_instr;
		logic illegal_trap;
		logic stop_recovery;
	} pvic_cpu_t;

	// asynchronous pin inputs
	typedef struct packed {
		logic [7:0] port_a;
		logic [3:0] port_d;
		logic [3:0] port_c;
		logic [1:0] cmp;
	} pvic_pin_t;

endpackage

// file: hw/pvic_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Port C pins interrupt on both edges
// - Port A pins 4..1 and D pins 3..0 share vectors
// - A5 and comparator 1 share vector
// - A0, timer A, multi-timer consecutive slots
// - fixed order only within same level
// - enable set by enable, return, write 1
// - enable cleared by reset, traps, ack, disable
// - three levels, higher level always wins
// - watchdog and oscillator fail at top level
// - one-cycle pulses latch into pending bits
// - acknowledge clears winning pending bit
// - software write 0 clears pending
// - software write 1 raises interrupt
// - watchdog and oscillator bypass registers
// - pending readable, forwarded when enabled
// - pending group 0 bit layout, reset 0
// - group 0 bits 2:1 read zero
// - level from high/low bit pair
module pvic_ctrl (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire pvic_pkg::pvic_src_t SRC_PULSE,
	input wire pvic_pkg::pvic_pin_t PINS,
	input wire pvic_pkg::pvic_cpu_t CPU_EVT,
	output logic IRQ_REQ,
	output logic [7:0] IRQ_VECTOR,
	output logic GLOBAL_IRQ_ENABLE
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------

	// winner search: walks from lowest to highest priority so that
	// among equal levels the earlier table slot is kept
	function automatic logic [5:0] pick(
		input logic [2:0][7:0] pend,
		input logic [2:0][7:0] hi,
		input logic [2:0][7:0] lo,
		input logic wd,
		input logic osc
	);
		logic [1:0] best;
		logic [1:0] lvl;
		logic [5:0] res;
		best = 2'h0;
		res = 6'h00;
		for (int g = 2; g >= 0; g--) begin
			for (int b = 0; b < 8; b++) begin
				lvl = {hi[g][b], lo[g][b]};
				if (pend[g][b] && lvl != 2'h0 && lvl >= best) begin
					best = lvl;
					res = {1'b1, 5'(2 + g * 8 + (7 - b))};
				end
			end
		end
		// fixed top level, no level bits involved; the watchdog still needs the enable
		if (osc) begin
			res = {1'b1, pvic_pkg::IDX_OSCF};
		end
		if (wd) begin
			res = {1'b1, pvic_pkg::IDX_WDOG};
		end
		return res;
	endfunction

	// vector address of a flattened source index
	function automatic logic [7:0] vec_of(input logic [4:0] idx);
		logic [4:0] k;
		logic [7:0] base;
		k = idx - pvic_pkg::IDX_GRP;
		case (k[4:3])
			2'h0: base = pvic_pkg::VEC_G0;
			2'h1: base = pvic_pkg::VEC_G2;
			default: base = pvic_pkg::VEC_G3;
		endcase
		if (idx == pvic_pkg::IDX_WDOG) begin
			vec_of = pvic_pkg::VEC_WDOG;
		end else if (idx == pvic_pkg::IDX_OSCF) begin
			vec_of = pvic_pkg::VEC_OSCF;
		end else begin
			vec_of = base + {4'h0, k[2:0], 1'b0};
		end
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [2:0][7:0] pend_reg, pend_next;
	logic [2:0][7:0] hi_reg, lo_reg;
	logic [7:0] edge_a_reg, edge_x_reg;
	logic gie_reg, gie_next;
	logic wd_reg, osc_reg;
	logic [17:0] s1_reg, s2_reg, s3_reg;
	logic [17:0] pin_reg;
	logic dph_reg, dph_write_reg;
	logic [11:0] dph_addr_reg;
	logic [31:0] rdata_reg;
	logic ready_reg;
	logic req_reg;
	logic [7:0] vec_reg;
	logic [4:0] win_reg;

	// ------------------------------------------------------------
	// pin synchroniser and edge detection
	// ------------------------------------------------------------

	// three stages; a change counts once stages two and three agree,
	// so a level still settling in stage two cannot fire an edge
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s1_reg <= 18'h0_0000;
			s2_reg <= 18'h0_0000;
			s3_reg <= 18'h0_0000;
			pin_reg <= 18'h0_0000;
		end else begin
			s1_reg <= PINS;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			pin_reg <= (s2_reg & s3_reg) |
				(pin_reg & (s2_reg ^ s3_reg));
		end
	end

	wire [17:0] rise = s2_reg & s3_reg & ~pin_reg;
	wire [17:0] fall = ~s2_reg & ~s3_reg & pin_reg;
	// positions: [17:10] port A, [9:6] port D, [5:2] port C, [1:0] cmp
	wire [7:0] pa_ev = (rise[17:10] & edge_a_reg) |
		(fall[17:10] & ~edge_a_reg);
	wire [3:0] pd_ev = (rise[9:6] & edge_x_reg[4:1]) |
		(fall[9:6] & ~edge_x_reg[4:1]);
	wire [3:0] pc_ev = rise[5:2] | fall[5:2];
	wire cmp0_ev = (rise[0] & edge_x_reg[6]) | (fall[0] & ~edge_x_reg[6]);
	wire cmp1_ev = (rise[1] & edge_x_reg[5]) | (fall[1] & ~edge_x_reg[5]);

	// hardware set vectors per group
	wire [7:0] hw0 = {SRC_PULSE.timer2, SRC_PULSE.timer1,
		SRC_PULSE.timer0, SRC_PULSE.serial_rx, SRC_PULSE.serial_tx,
		2'b00, SRC_PULSE.twowire};
	wire [7:0] hw2 = {pa_ev[7] | SRC_PULSE.lvd, pa_ev[6] | cmp0_ev,
		pa_ev[5] | cmp1_ev,
		pa_ev[4:1] | pd_ev, pa_ev[0]};
	wire [7:0] hw3 = {SRC_PULSE.timer_a, SRC_PULSE.mct, 2'b00,
		pc_ev};
	wire [2:0][7:0] hw_set = {hw3, hw2, hw0};
	wire [2:0][7:0] rmask = {pvic_pkg::MASK_G3, pvic_pkg::MASK_G2,
		pvic_pkg::MASK_G0};

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire addr_ok = HSEL && HTRANS[1] && HREADY;
	wire wr = dph_reg && dph_write_reg;
	wire wr_p0 = wr && dph_addr_reg == pvic_pkg::ADDR_PEND0;
	wire wr_p2 = wr && dph_addr_reg == pvic_pkg::ADDR_PEND2;
	wire wr_p3 = wr && dph_addr_reg == pvic_pkg::ADDR_PEND3;
	wire wr_ctl = wr && dph_addr_reg == pvic_pkg::ADDR_CTRL;
	wire [2:0] wr_pend = {wr_p3, wr_p2, wr_p0};
	wire [2:0] wr_hi = {wr && dph_addr_reg == pvic_pkg::ADDR_LVLH3,
		wr && dph_addr_reg == pvic_pkg::ADDR_LVLH2,
		wr && dph_addr_reg == pvic_pkg::ADDR_LVLH0};
	wire [2:0] wr_lo = {wr && dph_addr_reg == pvic_pkg::ADDR_LVLL3,
		wr && dph_addr_reg == pvic_pkg::ADDR_LVLL2,
		wr && dph_addr_reg == pvic_pkg::ADDR_LVLL0};
	wire [7:0] wbyte = HWDATA[7:0];

	// read selection; unmapped addresses read zero
	logic [31:0] rd_mux;
	always_comb begin
		case (dph_addr_reg)
			pvic_pkg::ADDR_PEND0: rd_mux = {24'h00_0000, pend_reg[0]};
			pvic_pkg::ADDR_PEND2: rd_mux = {24'h00_0000, pend_reg[1]};
			pvic_pkg::ADDR_PEND3: rd_mux = {24'h00_0000, pend_reg[2]};
			pvic_pkg::ADDR_CTRL: rd_mux = {24'h00_0000, gie_reg, 7'h00};
			pvic_pkg::ADDR_LVLH0: rd_mux = {24'h00_0000, hi_reg[0]};
			pvic_pkg::ADDR_LVLL0: rd_mux = {24'h00_0000, lo_reg[0]};
			pvic_pkg::ADDR_LVLH2: rd_mux = {24'h00_0000, hi_reg[1]};
			pvic_pkg::ADDR_LVLL2: rd_mux = {24'h00_0000, lo_reg[1]};
			pvic_pkg::ADDR_LVLH3: rd_mux = {24'h00_0000, hi_reg[2]};
			pvic_pkg::ADDR_LVLL3: rd_mux = {24'h00_0000, lo_reg[2]};
			pvic_pkg::ADDR_EDGEA: rd_mux = {24'h00_0000, edge_a_reg};
			pvic_pkg::ADDR_EDGEX: rd_mux = {24'h00_0000, edge_x_reg};
			pvic_pkg::ADDR_STAT: rd_mux = {23'h00_0000, req_reg, vec_reg};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// pending and enable next state
	// ------------------------------------------------------------
	wire ack = CPU_EVT.ack && req_reg;
	wire [4:0] wk = win_reg - pvic_pkg::IDX_GRP;

	// ack clears, write replaces, then hardware pulses are or-ed in
	always_comb begin
		pend_next = pend_reg;
		for (int g = 0; g < 3; g++) begin
			if (ack && win_reg >= pvic_pkg::IDX_GRP && wk[4:3] == 2'(g)) begin
				pend_next[g][3'h7 - wk[2:0]] = 1'b0;
			end
			if (wr_pend[g]) begin
				pend_next[g] = wbyte;
			end
			pend_next[g] = (pend_next[g] | hw_set[g]) & rmask[g];
		end
	end

	// clearing events win over setting ones in the same cycle
	always_comb begin
		gie_next = gie_reg;
		if (wr_ctl) begin
			gie_next = wbyte[pvic_pkg::CTRL_GIE_BIT];
		end
		if (CPU_EVT.enable_int_instr || CPU_EVT.int_return_instr) begin
			gie_next = 1'b1;
		end
		if (CPU_EVT.disable_int_instr || ack || CPU_EVT.trap_instr ||
			CPU_EVT.illegal_trap || SRC_PULSE.osc_fail ||
			CPU_EVT.stop_recovery) begin
			gie_next = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// arbitration
	// ------------------------------------------------------------
	wire [5:0] pick_res = pick(pend_reg, hi_reg, lo_reg, wd_reg, osc_reg);
	wire is_osc = pick_res[4:0] == pvic_pkg::IDX_OSCF;
	// the trap goes through whatever the enable says
	wire req_next = pick_res[5] && (gie_reg || is_osc) && !ack;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pend_reg <= {3{pvic_pkg::RST_BYTE}};
			gie_reg <= 1'b0;
			wd_reg <= 1'b0;
			osc_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			gie_reg <= gie_next;
			// hardware-only latches, set wins over acknowledge
			wd_reg <= SRC_PULSE.wdog ||
				(wd_reg && !(ack && win_reg == pvic_pkg::IDX_WDOG));
			osc_reg <= SRC_PULSE.osc_fail ||
				(osc_reg && !(ack && win_reg == pvic_pkg::IDX_OSCF));
		end
	end

	// level and edge configuration
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			hi_reg <= {3{pvic_pkg::RST_BYTE}};
			lo_reg <= {3{pvic_pkg::RST_BYTE}};
			edge_a_reg <= pvic_pkg::RST_EDGE;
			edge_x_reg <= pvic_pkg::RST_EDGE;
		end else begin
			for (int g = 0; g < 3; g++) begin
				if (wr_hi[g]) hi_reg[g] <= wbyte;
				if (wr_lo[g]) lo_reg[g] <= wbyte;
			end
			if (wr && dph_addr_reg == pvic_pkg::ADDR_EDGEA) edge_a_reg <= wbyte;
			if (wr && dph_addr_reg == pvic_pkg::ADDR_EDGEX) edge_x_reg <= wbyte;
		end
	end

	// one wait state per transfer keeps read data a plain flop
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			dph_reg <= 1'b0;
			dph_write_reg <= 1'b0;
			dph_addr_reg <= 12'h000;
			rdata_reg <= 32'h0000_0000;
			ready_reg <= 1'b1;
		end else begin
			dph_reg <= addr_ok;
			ready_reg <= !addr_ok;
			if (addr_ok) begin
				dph_write_reg <= HWRITE;
				dph_addr_reg <= HADDR[11:0];
			end
			if (dph_reg && !dph_write_reg) rdata_reg <= rd_mux;
		end
	end

	// presentation to the cpu
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			req_reg <= 1'b0;
			vec_reg <= 8'h00;
			win_reg <= 5'h00;
		end else begin
			req_reg <= req_next;
			vec_reg <= vec_of(pick_res[4:0]);
			win_reg <= pick_res[4:0];
		end
	end

	assign HRDATA = rdata_reg;
	assign HREADYOUT = ready_reg;
	assign HRESP = 1'b0;
	assign IRQ_REQ = req_reg;
	assign IRQ_VECTOR = vec_reg;
	assign GLOBAL_IRQ_ENABLE = gie_reg;

endmodule

`default_nettype wire

// file: tb/pvic_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pvic_assertions (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire pvic_pkg::pvic_src_t SRC_PULSE,
	input wire pvic_pkg::pvic_cpu_t CPU_EVT,
	input wire logic IRQ_REQ,
	input wire logic [7:0] IRQ_VECTOR,
	input wire logic GLOBAL_IRQ_ENABLE
);
	// ----
	// helpers
	// ----
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic clr_evt;
	logic rd_pend0;
	// cpu events that drop the enable whatever else happens
	assign clr_evt = CPU_EVT.disable_int_instr | CPU_EVT.trap_instr
		| CPU_EVT.illegal_trap | CPU_EVT.stop_recovery;
	assign rd_pend0 = HSEL & HTRANS[1] & HREADY & !HWRITE
		& (HADDR[11:0] == pvic_pkg::ADDR_PEND0);
	sequence s_one_wait;
		!HREADYOUT ##1 HREADYOUT;
	endsequence
	sequence s_taken;
		CPU_EVT.ack && IRQ_REQ;
	endsequence
	property p_wait;
		HSEL && HTRANS[1] && HREADY |=> s_one_wait;
	endproperty
	property p_okay;
		HRESP == 1'b0;
	endproperty
	property p_ack_off;
		s_taken |=> !GLOBAL_IRQ_ENABLE;
	endproperty
	property p_ack_drop;
		s_taken |-> ##[1:2] !IRQ_REQ;
	endproperty
	property p_clr;
		clr_evt |=> !GLOBAL_IRQ_ENABLE;
	endproperty
	// set only wins when no clear event shares the edge
	property p_set;
		(CPU_EVT.enable_int_instr || CPU_EVT.int_return_instr) && !clr_evt
			&& !CPU_EVT.ack && !SRC_PULSE.osc_fail |=> GLOBAL_IRQ_ENABLE;
	endproperty
	property p_wdog;
		SRC_PULSE.wdog && GLOBAL_IRQ_ENABLE && CPU_EVT == '0 |-> ##2
			(IRQ_REQ && IRQ_VECTOR == pvic_pkg::VEC_WDOG);
	endproperty
	property p_off;
		!GLOBAL_IRQ_ENABLE |=> !IRQ_REQ || IRQ_VECTOR == pvic_pkg::VEC_OSCF;
	endproperty
	property p_vec;
		IRQ_REQ |-> !IRQ_VECTOR[0] && IRQ_VECTOR >= pvic_pkg::VEC_WDOG
			&& IRQ_VECTOR <= pvic_pkg::VEC_OSCF;
	endproperty
	property p_rsv;
		rd_pend0 |-> ##2 HRDATA[2:1] == 2'b00 && HRDATA[31:8] == '0;
	endproperty
	a_wait: assert property (p_wait) else $error("bad wait state");
	a_okay: assert property (p_okay) else $error("bad response");
	a_ack_off: assert property (p_ack_off) else $error("ack kept enable");
	a_ack_drop: assert property (p_ack_drop) else $error("ack kept req");
	a_clr: assert property (p_clr) else $error("enable not cleared");
	a_set: assert property (p_set) else $error("enable not set");
	a_wdog: assert property (p_wdog) else $error("watchdog not top");
	a_off: assert property (p_off) else $error("req while disabled");
	a_vec: assert property (p_vec) else $error("vector out of table");
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule
bind pvic_ctrl pvic_assertions u_pvic_assertions (.CLK(CLK), .RST_N(RST_N),
	.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.SRC_PULSE(SRC_PULSE), .CPU_EVT(CPU_EVT), .IRQ_REQ(IRQ_REQ),
	.IRQ_VECTOR(IRQ_VECTOR), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE));
`default_nettype wire

// file: tb/pvic_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module pvic_cpu_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic irq_req,
	input wire logic [3:0] delay,
	output logic ack,
	output logic int_ret
);
	logic [3:0] cnt_reg;
	logic [1:0] ret_reg;
	// acks after a chosen delay, returns a few cycles later so the
	// next pending request can win; slow delays stress the hold
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			ret_reg <= '0;
			ack <= 1'b0;
			int_ret <= 1'b0;
		end else begin
			ack <= 1'b0;
			int_ret <= 1'b0;
			if (ret_reg != 2'b00) begin
				ret_reg <= ret_reg - 2'b01;
				int_ret <= (ret_reg == 2'b01);
			end else if (irq_req && !ack && cnt_reg == delay) begin
				ack <= 1'b1;
				ret_reg <= 2'b11;
				cnt_reg <= '0;
			end else if (irq_req && !ack) begin
				cnt_reg <= cnt_reg + 4'h1;
			end else begin
				cnt_reg <= '0;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic CLK, ack, int_ret, HREADYOUT, HRESP, IRQ_REQ, GLOBAL_IRQ_ENABLE;
	logic RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, rd_done = 1'b0;
	logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, r;
	logic [1:0] HTRANS = 2'b00;
	logic [7:0] IRQ_VECTOR, p, h, l;
	logic [3:0] dly = '0;
	logic [5:0] ev = '0;
	pvic_pkg::pvic_src_t src = '0;
	pvic_pkg::pvic_pin_t pins = '0;
	pvic_pkg::pvic_cpu_t cpu_evt;
	logic [31:0] rd_q[$];
	logic [7:0] vec_q[$];
	int errors = 0, n_compared = 0, cyc = 0, seed = 62;
	assign cpu_evt = {ack, ev[5:4], ev[3] | int_ret, ev[2:0]};
	pvic_ctrl u_pvic_ctrl (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .SRC_PULSE(src), .PINS(pins),
		.CPU_EVT(cpu_evt), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR),
		.GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE));
	pvic_cpu_model u_pvic_cpu_model (.clk(CLK), .rst_n(RST_N),
		.irq_req(IRQ_REQ), .delay(dly), .ack(ack), .int_ret(int_ret));
	// ----
	// shared tasks
	// ----
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (e !== g) begin
			errors++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task summarize;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// single word transfer, waits for the slave however long it takes
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [7:0] d, input logic [31:0] e);
		HSEL <= 1'b1;
		HTRANS <= 2'b10;
		HADDR <= {20'h0_0000, a};
		HWRITE <= w;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= {24'h00_0000, d};
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		if (!w)
			rd_q.push_back(e);
		rd_done <= !w;
	endtask
	task automatic pulse(input logic [10:0] s, input logic [5:0] e);
		src <= s;
		ev <= e;
		@(posedge CLK);
		src <= '0;
		ev <= '0;
	endtask
	// every noted vector must have been served, none left over
	task automatic drain;
		for (int i = 0; i < 300 && vec_q.size() != 0; i++)
			@(posedge CLK);
		repeat (10) @(posedge CLK);
		chk(32'h0000_0000, 32'(vec_q.size()));
		vec_q.delete();
	endtask
	// ----
	// clock, monitor, timeout
	// ----
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			summarize();
		end
		if (rd_done) begin
			chk(rd_q.pop_front(), HRDATA);
			rd_done <= 1'b0;
		end
		if (ack === 1'b1 && IRQ_REQ === 1'b1)
			chk({24'h00_0000, vec_q.pop_front()},
				{24'h00_0000, IRQ_VECTOR});
	end
	// ----
	// scenarios
	// ----
	initial begin
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		bus(0, pvic_pkg::ADDR_PEND0, 0, 0);
		bus(0, pvic_pkg::ADDR_CTRL, 0, 0);
		bus(0, 12'hffc, 0, 0);
		bus(1, pvic_pkg::ADDR_PEND0, 8'hf9, 0);
		bus(0, pvic_pkg::ADDR_PEND0, 0, 32'h0000_00f9);
		bus(1, pvic_pkg::ADDR_PEND0, 8'h00, 0);
		bus(0, pvic_pkg::ADDR_PEND0, 0, 0);
		$display("test registers done");
		for (int i = 0; i < 5; i++) begin
			bus(1, pvic_pkg::ADDR_CTRL, 8'h80, 0);
			bus(0, pvic_pkg::ADDR_CTRL, 0, 32'h0000_0080);
			pulse('0, 6'h01 << (i == 3 ? 4 : i));
			bus(0, pvic_pkg::ADDR_CTRL, 0, 0);
		end
		pulse('0, 6'h20);
		bus(0, pvic_pkg::ADDR_CTRL, 0, 32'h0000_0080);
		$display("test enable done");
		for (int k = 0; k < 8; k++) begin
			r = $random(seed);
			p = r[7:0] & pvic_pkg::MASK_G0;
			h = r[15:8];
			l = r[23:16];
			dly <= {2'b00, r[25:24]};
			bus(1, pvic_pkg::ADDR_LVLH0, h, 0);
			bus(1, pvic_pkg::ADDR_LVLL0, l, 0);
			bus(1, pvic_pkg::ADDR_PEND0, p, 0);
			for (int lv = 3; lv > 0; lv--)
				for (int b = 7; b >= 0; b--)
					if (p[b] && {h[b], l[b]} == lv[1:0]) begin
						vec_q.push_back(8'(8 + 14 - 2 * b));
						p[b] = 1'b0;
					end
			bus(1, pvic_pkg::ADDR_CTRL, 8'h80, 0);
			drain();
			bus(0, pvic_pkg::ADDR_PEND0, 0, {24'h00_0000, p});
			bus(1, pvic_pkg::ADDR_PEND0, 8'h00, 0);
		end
		$display("test priority done");
		bus(1, pvic_pkg::ADDR_LVLH0, 8'h20, 0);
		bus(1, pvic_pkg::ADDR_LVLL0, 8'h00, 0);
		vec_q.push_back(8'h04);
		vec_q.push_back(8'h0c);
		pulse(11'h102, '0);
		drain();
		bus(1, pvic_pkg::ADDR_LVLH3, 8'h01, 0);
		bus(1, pvic_pkg::ADDR_LVLL3, 8'h01, 0);
		bus(1, pvic_pkg::ADDR_LVLH2, 8'h02, 0);
		for (int s = 0; s < 4; s++) begin
			if (s != 3)
				vec_q.push_back(s < 2 ? 8'h46 : 8'h34);
			if (s < 2)
				pins.port_c[0] <= ~pins.port_c[0];
			else
				pins.port_d[0] <= ~pins.port_d[0];
			drain();
		end
		// collect while disabled, then check order within one level
		bus(1, pvic_pkg::ADDR_CTRL, 8'h00, 0);
		bus(0, pvic_pkg::ADDR_CTRL, 0, 0);
		bus(1, pvic_pkg::ADDR_LVLH2, 8'h21, 0);
		bus(1, pvic_pkg::ADDR_LVLH3, 8'hc1, 0);
		bus(1, pvic_pkg::ADDR_EDGEX, 8'hdf, 0);
		pins.port_a[0] <= 1'b1;
		pins.cmp[1] <= 1'b1;
		pulse(11'h00c, '0);
		repeat (8) @(posedge CLK);
		bus(0, pvic_pkg::ADDR_PEND2, 0, 32'h0000_0001);
		bus(0, pvic_pkg::ADDR_PEND3, 0, 32'h0000_00c0);
		pins.cmp[1] <= 1'b0;
		repeat (8) @(posedge CLK);
		vec_q.push_back(8'h2c);
		vec_q.push_back(8'h36);
		vec_q.push_back(8'h38);
		vec_q.push_back(8'h3a);
		bus(1, pvic_pkg::ADDR_CTRL, 8'h80, 0);
		drain();
		vec_q.push_back(8'h48);
		pulse(11'h001, '0);
		drain();
		$display("test sources done");
		summarize();
	end
endmodule
`default_nettype wire
